// file: verilog/sio_pkg.sv
// Package with offsets, reset values, counts and state codes of the supervisor register bank.
package sio_pkg;

  // Register offsets on the two-wire bus.
  localparam logic [7:0] OFS_STATUS_LO = 8'h03;
  localparam logic [7:0] OFS_STATUS_HI = 8'h04;
  localparam logic [7:0] OFS_SIG_B0 = 8'h0A;
  localparam logic [7:0] OFS_SIG_B1 = 8'h0B;
  localparam logic [7:0] OFS_SIG_B2 = 8'h0C;
  localparam logic [7:0] OFS_SIG_B3 = 8'h0D;
  localparam logic [7:0] OFS_OVR_LO = 8'h0E;
  localparam logic [7:0] OFS_OVR_HI = 8'h0F;
  localparam logic [7:0] OFS_IN_OVR = 8'h11;
  localparam logic [7:0] OFS_SOFT_RST = 8'h12;

  // Field positions.
  localparam int ALERT_REL_BIT = 2;
  localparam int ALERT_OUT_IDX = 2;

  // Values after reset and fill values for bits without function.
  localparam logic [7:0] OVR_LO_RST = 8'h04;
  localparam logic [5:0] OVR_HI_RST = 6'h00;
  localparam logic [2:0] IN_OVR_RST = 3'h0;
  localparam logic [7:0] READ_FILL = 8'hFF;

  // Alert response address of the bus.
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

  // Length of the soft reset pulse.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SOFT_RST_NS = 100;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [4:0] SOFT_RST_LEN = 5'(SOFT_RST_CYC);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_ACK = 6'b00_0100,
    ST_WR = 6'b00_1000,
    ST_RD = 6'b01_0000,
    ST_RACK = 6'b10_0000
  } sio_state_e;

endpackage

// file: verilog/sio_sync.sv
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module sio_sync #(
  parameter int W = 5
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Raw and synchronised levels.
  input wire logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sio_sync_s;

  sio_sync_s s_q;
  sio_sync_s s_d;

  always_comb
  begin
    s_d.meta = pin_raw;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pin_sync = s_q.stable;

endmodule

// file: verilog/sio_route.sv
// Source selection for the logic array inputs and the fourteen output drives.
`timescale 1ns/1ps
module sio_route (
  // Nonvolatile selections.
  input wire logic [2:0] input_src_sel,
  input wire logic [13:0] output_src_sel,
  input wire logic alert_feature_select,
  // Sources.
  input wire logic [2:0] pin_level,
  input wire logic [2:0] input_override,
  input wire logic [13:0] logic_array_out,
  input wire logic [7:0] override_lo,
  input wire logic [5:0] override_hi,
  // Selected values.
  output logic [2:0] array_in_d,
  output logic [13:0] drive_d
);

  logic [13:0] ovr_vec;

  always_comb
  begin
    array_in_d = (input_src_sel & input_override) | (~input_src_sel & pin_level);
    // Output 3 has no override value; its register bit is the alert release.
    ovr_vec = {override_hi, override_lo[7:3], logic_array_out[sio_pkg::ALERT_OUT_IDX], override_lo[1:0]};
    drive_d = (output_src_sel & ovr_vec) | (~output_src_sel & logic_array_out);
    if (alert_feature_select)
    begin
      drive_d[sio_pkg::ALERT_OUT_IDX] = logic_array_out[sio_pkg::ALERT_OUT_IDX] |
                                        override_lo[sio_pkg::ALERT_REL_BIT];
    end
  end

endmodule

// file: verilog/sio_bank.sv
// Two-wire slave register bank with output overrides, signature, soft reset and alert response.
//
// Overview of operation
// - Input override register bits 3:1 hold values for digital inputs 4..2.
// - Logic array takes override bit only when its selector picks the register.
// - Bits without function read back as one.
// - Output status shows the internal drive value, not the pin level.
// - Status low byte: outputs 1,2 on bits 0,1, outputs 3..8 on bits 2..7.
// - Status high byte: outputs 9..14 on bits 0..5, bits 6,7 read one.
// - Each output except 3 comes from logic array or its override bit, per selector.
// - Override low register holds outputs 1,2,4..8; bit 2 is alert release.
// - Override high register holds outputs 9..14 in bits 0..5.
// - Signature is four read-only bytes, least significant byte at lowest address.
// - Any write to the reset register resets the whole device.
// - In alert mode output 3 combines logic array output and release bit.
// - Host clears release bit to arm; logic array then pulls output 3 low.
// - While alerting, device answers that read with its own address, arbitrating.
// - Winning the arbitration sets the release bit, freeing output 3.
`timescale 1ns/1ps
module sio_bank (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Two-wire bus.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Nonvolatile configuration.
  input wire logic [6:0] slave_addr,
  input wire logic [2:0] input_src_sel,
  input wire logic [13:0] output_src_sel,
  input wire logic alert_feature_select,
  input wire logic [31:0] user_signature,
  // Logic array and pins.
  input wire logic [2:0] digital_input_pin,
  input wire logic [13:0] logic_array_out,
  output logic [2:0] logic_array_in,
  output logic [13:0] out_drive,
  output logic device_soft_reset
);

  typedef struct packed {
    sio_pkg::sio_state_e st;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic rd_mode;
    logic ptr_phase;
    logic [7:0] ptr;
    logic ara;
    logic arb_lost;
    logic sda_drive;
    logic sda_level;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] ovr_lo;
    logic [5:0] ovr_hi;
    logic [2:0] in_ovr;
    logic [13:0] drive;
    logic [2:0] array_in;
    logic [4:0] srst_cnt;
    logic srst;
  } sio_bank_s;

  sio_bank_s s_q;
  sio_bank_s s_d;
  logic [4:0] sync_out;
  logic [2:0] array_in_d;
  logic [13:0] drive_d;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic wr_fire;
  logic ara_win;
  logic alert_pending;

  // Read data for one register offset.
  function automatic logic [7:0] rd_byte(input logic [7:0] ofs, input sio_bank_s r, input logic [31:0] sig);
    logic [7:0] v;
    v = sio_pkg::READ_FILL;
    unique case (ofs)
      sio_pkg::OFS_STATUS_LO: v = r.drive[7:0];
      sio_pkg::OFS_STATUS_HI: v = {2'b11, r.drive[13:8]};
      sio_pkg::OFS_SIG_B0: v = sig[7:0];
      sio_pkg::OFS_SIG_B1: v = sig[15:8];
      sio_pkg::OFS_SIG_B2: v = sig[23:16];
      sio_pkg::OFS_SIG_B3: v = sig[31:24];
      sio_pkg::OFS_OVR_LO: v = r.ovr_lo;
      sio_pkg::OFS_OVR_HI: v = {2'b11, r.ovr_hi};
      sio_pkg::OFS_IN_OVR: v = {4'hF, r.in_ovr, 1'b1};
      default: v = sio_pkg::READ_FILL;
    endcase
    return v;
  endfunction

  sio_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_raw({digital_input_pin, sda_i, scl_i}),
    .pin_sync(sync_out)
  );

  sio_route u_route (
    .input_src_sel(input_src_sel),
    .output_src_sel(output_src_sel),
    .alert_feature_select(alert_feature_select),
    .pin_level(sync_out[4:2]),
    .input_override(s_q.in_ovr),
    .logic_array_out(logic_array_out),
    .override_lo(s_q.ovr_lo),
    .override_hi(s_q.ovr_hi),
    .array_in_d(array_in_d),
    .drive_d(drive_d)
  );

  assign scl = sync_out[0];
  assign sda = sync_out[1];
  assign scl_rise = scl & ~s_q.scl_prev;
  assign scl_fall = ~scl & s_q.scl_prev;
  // The device is alerting while output 3 is held low in alert mode.
  assign alert_pending = alert_feature_select & ~s_q.drive[sio_pkg::ALERT_OUT_IDX];

  always_comb
  begin
    s_d = s_q;
    wr_fire = 1'b0;
    ara_win = 1'b0;
    s_d.scl_prev = scl;
    s_d.sda_prev = sda;
    s_d.sda_level = 1'b0;
    s_d.drive = drive_d;
    s_d.array_in = array_in_d;
    if (s_q.srst_cnt != 5'h00)
    begin
      s_d.srst_cnt = s_q.srst_cnt - 5'h01;
    end
    if (scl & s_q.scl_prev & s_q.sda_prev & ~sda)
    begin
      s_d.st = sio_pkg::ST_ADDR;
      s_d.bit_cnt = 4'h0;
      s_d.sda_drive = 1'b0;
      s_d.ara = 1'b0;
      s_d.arb_lost = 1'b0;
    end
    else if (scl & s_q.scl_prev & ~s_q.sda_prev & sda)
    begin
      s_d.st = sio_pkg::ST_IDLE;
      s_d.sda_drive = 1'b0;
    end
    else
    begin
      unique case (s_q.st)
        sio_pkg::ST_IDLE:
        begin
          s_d.sda_drive = 1'b0;
        end
        sio_pkg::ST_ADDR, sio_pkg::ST_WR:
        begin
          if (scl_rise)
          begin
            s_d.shift = {s_q.shift[6:0], sda};
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
          else if (scl_fall && s_q.bit_cnt == 4'h8)
          begin
            s_d.bit_cnt = 4'h0;
            s_d.sda_drive = 1'b1;
            s_d.st = sio_pkg::ST_ACK;
            if (s_q.st == sio_pkg::ST_ADDR)
            begin
              if (s_q.shift[7:1] == slave_addr)
              begin
                s_d.rd_mode = s_q.shift[0];
                s_d.ptr_phase = ~s_q.shift[0];
              end
              else if (s_q.shift[7:1] == sio_pkg::ALERT_RESP_ADDR && s_q.shift[0] && alert_pending)
              begin
                s_d.rd_mode = 1'b1;
                s_d.ara = 1'b1;
              end
              else
              begin
                s_d.sda_drive = 1'b0;
                s_d.st = sio_pkg::ST_IDLE;
              end
            end
            else if (s_q.ptr_phase)
            begin
              s_d.ptr = s_q.shift;
              s_d.ptr_phase = 1'b0;
            end
            else
            begin
              wr_fire = 1'b1;
              s_d.ptr = s_q.ptr + 8'h01;
            end
          end
        end
        sio_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            s_d.sda_drive = 1'b0;
            s_d.bit_cnt = 4'h0;
            if (s_q.rd_mode)
            begin
              if (s_q.ara)
              begin
                s_d.shift = {slave_addr, 1'b0};
              end
              else
              begin
                s_d.shift = rd_byte(s_q.ptr, s_q, user_signature);
                s_d.ptr = s_q.ptr + 8'h01;
              end
              s_d.sda_drive = ~s_d.shift[7];
              s_d.st = sio_pkg::ST_RD;
            end
            else
            begin
              s_d.st = sio_pkg::ST_WR;
            end
          end
        end
        sio_pkg::ST_RD:
        begin
          if (scl_rise)
          begin
            if (s_q.ara && !s_q.sda_drive && !sda)
            begin
              s_d.arb_lost = 1'b1;
            end
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (s_q.bit_cnt == 4'h8)
            begin
              s_d.sda_drive = 1'b0;
              s_d.st = sio_pkg::ST_RACK;
            end
            else
            begin
              s_d.shift = {s_q.shift[6:0], 1'b1};
              s_d.sda_drive = ~s_q.shift[6] & ~s_q.arb_lost;
            end
          end
        end
        sio_pkg::ST_RACK:
        begin
          if (scl_rise)
          begin
            if (s_q.ara)
            begin
              ara_win = ~s_q.arb_lost;
              s_d.st = sio_pkg::ST_IDLE;
            end
            else if (!sda)
            begin
              s_d.st = sio_pkg::ST_ACK;
            end
            else
            begin
              s_d.st = sio_pkg::ST_IDLE;
            end
          end
        end
        default:
        begin
          s_d.st = sio_pkg::ST_IDLE;
          s_d.sda_drive = 1'b0;
        end
      endcase
    end
    // Writes to read-only offsets fall through and change nothing.
    if (wr_fire)
    begin
      case (s_q.ptr)
        sio_pkg::OFS_OVR_LO: s_d.ovr_lo = s_q.shift;
        sio_pkg::OFS_OVR_HI: s_d.ovr_hi = s_q.shift[5:0];
        sio_pkg::OFS_IN_OVR: s_d.in_ovr = s_q.shift[3:1];
        sio_pkg::OFS_SOFT_RST: s_d.srst_cnt = sio_pkg::SOFT_RST_LEN;
        default: s_d.ovr_lo = s_q.ovr_lo;
      endcase
    end
    if (ara_win)
    begin
      s_d.ovr_lo[sio_pkg::ALERT_REL_BIT] = 1'b1;
    end
    // A soft reset returns the host registers to their values after power-up.
    if (s_q.srst)
    begin
      s_d.ovr_lo = sio_pkg::OVR_LO_RST;
      s_d.ovr_hi = sio_pkg::OVR_HI_RST;
      s_d.in_ovr = sio_pkg::IN_OVR_RST;
    end
    s_d.srst = (s_d.srst_cnt != 5'h00);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.st <= sio_pkg::ST_IDLE;
      s_q.ovr_lo <= sio_pkg::OVR_LO_RST;
      s_q.ovr_hi <= sio_pkg::OVR_HI_RST;
      s_q.in_ovr <= sio_pkg::IN_OVR_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sda_o = s_q.sda_level;
  assign sda_oe = s_q.sda_drive;
  assign logic_array_in = s_q.array_in;
  assign out_drive = s_q.drive;
  assign device_soft_reset = s_q.srst;

  chk_input_route: assert property (@(posedge clk) disable iff (rst)
    ##1 logic_array_in == (($past(input_src_sel) & $past(s_q.in_ovr)) | (~$past(input_src_sel) & $past(sync_out[4:2]))))
    else $error("logic array input does not follow its selected source");

  chk_drive_route: assert property (@(posedge clk) disable iff (rst)
    ##1 out_drive[0] == ($past(output_src_sel[0]) ? $past(s_q.ovr_lo[0]) : $past(logic_array_out[0])))
    else $error("output 1 drive does not follow its selected source");

  chk_alert_level: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && alert_feature_select && $past(alert_feature_select) |->
      out_drive[2] == ($past(logic_array_out[2]) | $past(s_q.ovr_lo[2])))
    else $error("alert output level is not array output or release bit");

  chk_alert_armed: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && alert_feature_select && $past(alert_feature_select) && !out_drive[2] |-> !$past(s_q.ovr_lo[2]))
    else $error("alert asserted while release bit was high");

  chk_reserved_ones: assert property (@(posedge clk) disable iff (rst)
    (rd_byte(sio_pkg::OFS_IN_OVR, s_q, user_signature) & 8'hF1) == 8'hF1 &&
    (rd_byte(sio_pkg::OFS_STATUS_HI, s_q, user_signature) & 8'hC0) == 8'hC0)
    else $error("bits without function do not read as one");

  chk_signature_map: assert property (@(posedge clk) disable iff (rst)
    rd_byte(sio_pkg::OFS_SIG_B3, s_q, user_signature) == user_signature[31:24] &&
    rd_byte(sio_pkg::OFS_SIG_B0, s_q, user_signature) == user_signature[7:0])
    else $error("signature bytes are in the wrong order");

  chk_soft_reset: assert property (@(posedge clk) disable iff (rst)
    wr_fire && s_q.ptr == sio_pkg::OFS_SOFT_RST |=> device_soft_reset [*8])
    else $error("write to reset register did not pulse soft reset");

  chk_override_write: assert property (@(posedge clk) disable iff (rst)
    wr_fire && s_q.ptr == sio_pkg::OFS_OVR_LO && !s_q.srst && !ara_win |=> s_q.ovr_lo == $past(s_q.shift))
    else $error("override low register did not take the written byte");

  chk_ro_ignored: assert property (@(posedge clk) disable iff (rst)
    wr_fire && s_q.ptr == sio_pkg::OFS_STATUS_LO && !s_q.srst && !ara_win |=>
      $stable(s_q.ovr_lo) && $stable(s_q.ovr_hi) && $stable(s_q.in_ovr))
    else $error("write to read-only status changed a register");

  chk_alert_release: assert property (@(posedge clk) disable iff (rst)
    ara_win |=> s_q.ovr_lo[sio_pkg::ALERT_REL_BIT])
    else $error("won alert response did not set release bit");

endmodule

// file: verif/sio_host.sv
// Two-wire bus controller model that drives the clock and data lines of the register bank.
`timescale 1ns/1ps
module sio_host (
  // Clock.
  input wire logic clk,
  // Bus lines; the data line has a pull-up, so releasing it reads as one.
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // Half bit time in clock cycles; the bench raises it to run the bus slowly.
  int hp_cyc = 12;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data only moves while the clock line is low, so no bit is taken for a start or stop.
  task automatic bus_start();
    sda_low <= 1'b0;
    wait_cyc(hp_cyc);
    scl <= 1'b1;
    wait_cyc(hp_cyc);
    sda_low <= 1'b1;
    wait_cyc(hp_cyc);
    scl <= 1'b0;
    wait_cyc(hp_cyc / 2);
  endtask

  task automatic bus_stop();
    sda_low <= 1'b1;
    wait_cyc(hp_cyc);
    scl <= 1'b1;
    wait_cyc(hp_cyc);
    sda_low <= 1'b0;
    wait_cyc(hp_cyc);
  endtask

  task automatic xbit(input logic b, output logic r);
    sda_low <= ~b;
    wait_cyc(hp_cyc);
    scl <= 1'b1;
    wait_cyc(hp_cyc);
    r = sda_in;
    scl <= 1'b0;
    wait_cyc(hp_cyc / 2);
  endtask

  // A one in d leaves the line to the slave; mack_n is sent in the acknowledge slot.
  task automatic xbyte(input logic [7:0] d, input logic mack_n, output logic [7:0] r, output logic ack_n);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r[i]);
    xbit(mack_n, ack_n);
  endtask

  task automatic reg_write(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    bus_start();
    xbyte({dev, 1'b0}, 1'b1, r, a0);
    xbyte(ptr, 1'b1, r, a1);
    xbyte(d, 1'b1, r, a2);
    bus_stop();
    ok = ~(a0 | a1 | a2);
  endtask

  task automatic reg_read(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    bus_start();
    xbyte({dev, 1'b0}, 1'b1, d, a);
    xbyte(ptr, 1'b1, d, a);
    bus_start();
    xbyte({dev, 1'b1}, 1'b1, d, a);
    xbyte(8'hFF, 1'b1, d, a);
    bus_stop();
  endtask

  // Alert response read; rival holds the address bits of a competing alerting slave.
  task automatic alert_read(input logic [7:0] rival, output logic [7:0] d, output logic ack_n);
    logic a;
    bus_start();
    xbyte({sio_pkg::ALERT_RESP_ADDR, 1'b1}, 1'b1, d, ack_n);
    xbyte(rival, 1'b1, d, a);
    bus_stop();
  endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the supervisor register bank.
`timescale 1ns/1ps
module tb_top;
  localparam logic [6:0] DEV = 7'h5A;
  localparam logic [31:0] SIG = 32'h1357_9BDF;
  localparam logic [13:0] OSEL = 14'h0F0F;

  logic clk = 1'b0;
  logic rst;
  logic [2:0] in_pin;
  logic [13:0] arr;
  logic alert_mode;
  logic [2:0] array_in;
  logic [13:0] drive;
  logic soft_rst;
  logic sda_o;
  logic sda_oe;
  logic scl;
  logic sda_low;
  wire sda_line = ~(sda_low | (sda_oe & ~sda_o));
  int error_cnt = 0;
  int checks_done = 0;
  int pulse_cnt = 0;

  always #2.5 clk = ~clk;

  always @(posedge clk)
    if (soft_rst === 1'b1)
      pulse_cnt++;

  sio_bank u_sio_bank (
    .clk(clk),
    .rst(rst),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .slave_addr(DEV),
    .input_src_sel(3'b011),
    .output_src_sel(OSEL),
    .alert_feature_select(alert_mode),
    .user_signature(SIG),
    .digital_input_pin(in_pin),
    .logic_array_out(arr),
    .logic_array_in(array_in),
    .out_drive(drive),
    .device_soft_reset(soft_rst)
  );

  sio_host u_sio_host (
    .clk(clk),
    .sda_in(sda_line),
    .scl(scl),
    .sda_low(sda_low)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    u_sio_host.reg_read(DEV, ofs, d);
    check(16'(d), 16'(exp));
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    u_sio_host.reg_write(DEV, ofs, d, ok);
    check(16'(ok), 16'h0001);
  endtask

  function automatic logic [13:0] exp_drive(input logic [7:0] lo, input logic [5:0] hi);
    logic [13:0] ov;
    logic [13:0] e;
    ov = {hi, lo};
    for (int i = 0; i < 14; i++)
      e[i] = OSEL[i] ? ov[i] : arr[i];
    e[2] = arr[2] | lo[2];
    return e;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    finish_test();
  end

  initial
  begin
    logic [7:0] d;
    logic a;
    logic [13:0] e;
    rst = 1'b1;
    in_pin = 3'b010;
    arr = 14'h3CC6;
    alert_mode = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);

    rd_chk(8'h0E, 8'h04);
    rd_chk(8'h0F, 8'hC0);
    rd_chk(8'h11, 8'hF1);
    rd_chk(8'h12, 8'hFF);
    rd_chk(8'h20, 8'hFF);
    $display("test reset_values done");

    // Without alert mode output 3 follows the array even though its override is selected.
    arr <= 14'h3CC2;
    repeat (2) @(posedge clk);
    check(16'(drive[2]), 16'h0000);
    alert_mode <= 1'b1;
    repeat (2) @(posedge clk);
    check(16'(drive[2]), 16'h0001);
    arr <= 14'h3CC6;
    $display("test alert_mode done");

    wr(8'h11, 8'h0A);
    rd_chk(8'h11, 8'hFB);
    check(16'(array_in), 16'h0001);
    in_pin <= 3'b110;
    repeat (8) @(posedge clk);
    check(16'(array_in), 16'h0005);
    $display("test input_override done");

    wr(8'h0E, 8'hA9);
    wr(8'h0F, 8'h15);
    e = exp_drive(8'hA9, 6'h15);
    check(16'(drive), 16'(e));
    rd_chk(8'h0E, 8'hA9);
    rd_chk(8'h0F, 8'hD5);
    wr(8'h03, ~e[7:0]);
    rd_chk(8'h03, e[7:0]);
    rd_chk(8'h04, {2'b11, e[13:8]});
    wr(8'h0B, 8'h00);
    for (int i = 0; i < 4; i++)
      rd_chk(8'h0A + 8'(i), SIG[8 * i +: 8]);
    $display("test outputs_signature done");

    u_sio_host.hp_cyc = 30;
    arr <= 14'h3CC2;
    repeat (4) @(posedge clk);
    check(16'(drive[2]), 16'h0000);
    u_sio_host.alert_read(8'h00, d, a);
    check(16'(a), 16'h0000);
    check(16'(drive[2]), 16'h0000);
    u_sio_host.alert_read(8'hFF, d, a);
    check(16'(d), 16'({DEV, 1'b0}));
    check(16'(drive[2]), 16'h0001);
    rd_chk(8'h0E, 8'hAD);
    u_sio_host.alert_read(8'hFF, d, a);
    check(16'(a), 16'h0001);
    wr(8'h0E, 8'hA9);
    check(16'(drive[2]), 16'h0000);
    u_sio_host.hp_cyc = 12;
    $display("test alert_flow done");

    wr(8'h12, 8'h5A);
    check(16'(pulse_cnt), 16'(sio_pkg::SOFT_RST_CYC));
    rd_chk(8'h0E, 8'h04);
    rd_chk(8'h11, 8'hF1);
    check(16'(drive), 16'(exp_drive(8'h04, 6'h00)));
    $display("test soft_reset done");

    finish_test();
  end
endmodule
